// ==== drp_regs.sv ====
/*
  Duty and reference profile register bank: APB slave holding the
  three-phase step profile and reference profile words, with every field
  but the parity bit 31 decoded and registered for the drive logic.
  Assumes an APB master on clk, one request at a time; rst synchronous.
*/
`timescale 1ns/1ps
module drp_regs
  import drp_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  output logic [23:0]            tri_phase_step_codes,
  output logic [111:0]           tri_phase_step_duty,
  output logic [2:0]             tri_phase_duty_step_first,
  output logic [2:0]             tri_phase_duty_step_fifth,
  output logic [1:0]             commutation_advance_angle,
  output logic [3:0]             advance_degrees,
  output drp_mode_t              profile_mode,
  output logic [7:0]             turn_on_duty_first,
  output logic [7:0]             turn_off_duty_first,
  output logic [7:0]             clamp_duty_first,
  output logic [7:0]             duty_point_a,
  output logic [7:0]             duty_point_b,
  output logic [7:0]             duty_point_c,
  output logic [7:0]             duty_point_d,
  output logic [7:0]             duty_point_e,
  output logic [7:0]             turn_on_duty_second,
  output logic [7:0]             turn_off_duty_second,
  output logic [7:0]             clamp_duty_second,
  output logic [1:0]             step_change_hysteresis,
  output logic [2:0]             hysteresis_percent,
  output logic [7:0]             turn_off_reference_first,
  output logic [7:0]             clamp_reference_first,
  output logic [7:0]             reference_point_a,
  output logic [7:0]             reference_point_b
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Word slot of a byte address; misaligned or unknown gives NONE
  function automatic logic [2:0] slot_of(input logic [ADDR_W-1:0] a);
    logic [11:0] a12;
    a12 = 12'(a);
    if (a12 == DRP_ADDR_TRI) return DRP_SLOT_TRI;
    else if (a12 == DRP_ADDR_REF1) return DRP_SLOT_REF1;
    else if (a12 == DRP_ADDR_REF2) return DRP_SLOT_REF2;
    else if (a12 == DRP_ADDR_REF3) return DRP_SLOT_REF3;
    else if (a12 == DRP_ADDR_REF4) return DRP_SLOT_REF4;
    else if (a12 == DRP_ADDR_REF5) return DRP_SLOT_REF5;
    else return DRP_SLOT_NONE;
  endfunction

  // One byte field of a word
  function automatic logic [7:0] byte_at(input logic [31:0] w, input int unsigned lsb);
    return w[lsb +: 8];
  endfunction

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic [31:0] regs_q [DRP_NREGS];
  logic [2:0]  slot;
  logic        setup;
  logic        access_q;

  assign slot  = slot_of(paddr);
  assign setup = psel && !penable;

  // Answer is prepared at setup so every access phase lasts one cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0000_0000;
      access_q <= 1'b0;
    end else begin
      pready   <= setup;
      access_q <= setup;
      if (setup) begin
        pslverr <= (slot == DRP_SLOT_NONE);
        // Reads have no side effect and return stored words
        prdata  <= (pwrite || slot == DRP_SLOT_NONE) ? 32'h0000_0000 : regs_q[slot];
      end else begin
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
      end
    end
  end

  // Storage; a write lands only at the edge that completes the access
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < DRP_NREGS; i++) begin
        regs_q[i] <= DRP_RESET_WORD;
      end
    end else if (access_q && psel && penable && pwrite && slot != DRP_SLOT_NONE) begin
      regs_q[slot] <= merge(regs_q[slot], pwdata, pstrb);
    end
  end

  // ----------------------------------------------------------------
  // Three-phase step profile decode
  // ----------------------------------------------------------------
  logic [31:0] w_tri;
  assign w_tri = regs_q[DRP_SLOT_TRI];

  // Step codes and their duty in hundredths of a percent
  always_ff @(posedge clk) begin
    if (rst) begin
      tri_phase_step_codes <= 24'h00_0000;
      tri_phase_step_duty  <= '0;
    end else begin
      for (int n = 0; n < DRP_NSTEPS; n++) begin
        tri_phase_step_codes[3*n +: 3] <= w_tri[DRP_STEP0_LSB - 3*n +: 3];
        tri_phase_step_duty[14*n +: 14] <=
          DRP_STEP_DUTY[w_tri[DRP_STEP0_LSB - 3*n +: 3]];
      end
    end
  end

  // Named steps and lead advance; reserved bits 4-0 feed nothing
  always_ff @(posedge clk) begin
    if (rst) begin
      tri_phase_duty_step_first <= 3'h0;
      tri_phase_duty_step_fifth <= 3'h0;
      commutation_advance_angle <= 2'h0;
      advance_degrees           <= 4'h0;
    end else begin
      tri_phase_duty_step_first <= w_tri[DRP_STEP0_LSB +: DRP_STEP_W];
      tri_phase_duty_step_fifth <= w_tri[DRP_STEP0_LSB - 12 +: DRP_STEP_W];
      commutation_advance_angle <= w_tri[DRP_ADV_LSB +: 2];
      advance_degrees           <= DRP_ADV_DEG[w_tri[DRP_ADV_LSB +: 2]];
    end
  end

  // ----------------------------------------------------------------
  // Reference profile decode
  // ----------------------------------------------------------------
  logic [31:0] w1, w2, w3, w4, w5;
  assign w1 = regs_q[DRP_SLOT_REF1];
  assign w2 = regs_q[DRP_SLOT_REF2];
  assign w3 = regs_q[DRP_SLOT_REF3];
  assign w4 = regs_q[DRP_SLOT_REF4];
  assign w5 = regs_q[DRP_SLOT_REF5];

  // Mode and first threshold set; counts scale as value/255 downstream
  always_ff @(posedge clk) begin
    if (rst) begin
      profile_mode        <= DRP_MODE_DUTY;
      turn_on_duty_first  <= 8'h00;
      turn_off_duty_first <= 8'h00;
      clamp_duty_first    <= 8'h00;
    end else begin
      profile_mode        <= drp_mode_t'(w1[DRP_MODE_LSB +: 2]);
      turn_on_duty_first  <= byte_at(w1, DRP_ON1_LSB);
      turn_off_duty_first <= byte_at(w1, DRP_OFF1_LSB);
      clamp_duty_first    <= byte_at(w1, DRP_CLAMP1_LSB);
    end
  end

  // Duty points; A and E are joined from two words, each half changing when its own word is written
  always_ff @(posedge clk) begin
    if (rst) begin
      duty_point_a <= 8'h00;
      duty_point_b <= 8'h00;
      duty_point_c <= 8'h00;
      duty_point_d <= 8'h00;
      duty_point_e <= 8'h00;
    end else begin
      duty_point_a <= {w1[DRP_A_HI_LSB +: 5], w2[DRP_A_LO_LSB +: 3]};
      duty_point_b <= byte_at(w2, DRP_B_LSB);
      duty_point_c <= byte_at(w2, DRP_C_LSB);
      duty_point_d <= byte_at(w2, DRP_D_LSB);
      duty_point_e <= {w2[DRP_E_HI_LSB +: 4], w3[DRP_E_LO_LSB +: 4]};
    end
  end

  // Second threshold set and step hysteresis band
  always_ff @(posedge clk) begin
    if (rst) begin
      turn_on_duty_second    <= 8'h00;
      turn_off_duty_second   <= 8'h00;
      clamp_duty_second      <= 8'h00;
      step_change_hysteresis <= 2'h0;
      hysteresis_percent     <= 3'h0;
    end else begin
      turn_on_duty_second    <= byte_at(w3, DRP_ON2_LSB);
      turn_off_duty_second   <= byte_at(w3, DRP_OFF2_LSB);
      clamp_duty_second      <= byte_at(w3, DRP_CLAMP2_LSB);
      step_change_hysteresis <= w3[DRP_HYST_LSB +: 2];
      hysteresis_percent     <= DRP_HYST_PCT[w3[DRP_HYST_LSB +: 2]];
    end
  end

  // Reference points; B straddles words 4 and 5
  always_ff @(posedge clk) begin
    if (rst) begin
      turn_off_reference_first <= 8'h00;
      clamp_reference_first    <= 8'h00;
      reference_point_a        <= 8'h00;
      reference_point_b        <= 8'h00;
    end else begin
      turn_off_reference_first <= byte_at(w4, DRP_ROFF1_LSB);
      clamp_reference_first    <= byte_at(w4, DRP_RCLAMP1_LSB);
      reference_point_a        <= byte_at(w4, DRP_RA_LSB);
      reference_point_b        <= {w4[DRP_RB_HI_LSB +: 7], w5[DRP_RB_LO_BIT]};
    end
  end

endmodule

// ==== drp_pkg.sv ====
/*
  Package of the duty and reference profile register bank: word indices,
  byte addresses, field positions, reset values and the decode tables of
  the coded fields.
  Assumes a 32-bit APB slave where each word index sits at byte index*4.
*/
package drp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned DRP_NREGS = 6;
  localparam logic [9:0] DRP_IDX_TRI  = 10'h098;  // Three-phase step profile
  localparam logic [9:0] DRP_IDX_REF1 = 10'h09a;
  localparam logic [9:0] DRP_IDX_REF2 = 10'h09c;
  localparam logic [9:0] DRP_IDX_REF3 = 10'h09e;
  localparam logic [9:0] DRP_IDX_REF4 = 10'h0a0;
  localparam logic [9:0] DRP_IDX_REF5 = 10'h0a2;  // Holds the low bit of point B
  localparam logic [11:0] DRP_ADDR_TRI  = {DRP_IDX_TRI, 2'b00};
  localparam logic [11:0] DRP_ADDR_REF1 = {DRP_IDX_REF1, 2'b00};
  localparam logic [11:0] DRP_ADDR_REF2 = {DRP_IDX_REF2, 2'b00};
  localparam logic [11:0] DRP_ADDR_REF3 = {DRP_IDX_REF3, 2'b00};
  localparam logic [11:0] DRP_ADDR_REF4 = {DRP_IDX_REF4, 2'b00};
  localparam logic [11:0] DRP_ADDR_REF5 = {DRP_IDX_REF5, 2'b00};

  // Slots of the storage array
  localparam logic [2:0] DRP_SLOT_TRI  = 3'h0;
  localparam logic [2:0] DRP_SLOT_REF1 = 3'h1;
  localparam logic [2:0] DRP_SLOT_REF2 = 3'h2;
  localparam logic [2:0] DRP_SLOT_REF3 = 3'h3;
  localparam logic [2:0] DRP_SLOT_REF4 = 3'h4;
  localparam logic [2:0] DRP_SLOT_REF5 = 3'h5;
  localparam logic [2:0] DRP_SLOT_NONE = 3'h7;

  localparam logic [31:0] DRP_RESET_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Field positions (lowest bit of each field)
  // ----------------------------------------------------------------
  localparam int unsigned DRP_PARITY_BIT  = 31;
  localparam int unsigned DRP_STEP0_LSB   = 28;  // Step n at 28 - 3n
  localparam int unsigned DRP_STEP_W      = 3;
  localparam int unsigned DRP_NSTEPS      = 8;
  localparam int unsigned DRP_ADV_LSB     = 5;
  localparam int unsigned DRP_MODE_LSB    = 29;
  localparam int unsigned DRP_ON1_LSB     = 21;
  localparam int unsigned DRP_OFF1_LSB    = 13;
  localparam int unsigned DRP_CLAMP1_LSB  = 5;
  localparam int unsigned DRP_A_HI_LSB    = 0;   // Word 1, 5 bits
  localparam int unsigned DRP_A_LO_LSB    = 28;  // Word 2, 3 bits
  localparam int unsigned DRP_B_LSB       = 20;
  localparam int unsigned DRP_C_LSB       = 12;
  localparam int unsigned DRP_D_LSB       = 4;
  localparam int unsigned DRP_E_HI_LSB    = 0;   // Word 2, 4 bits
  localparam int unsigned DRP_E_LO_LSB    = 27;  // Word 3, 4 bits
  localparam int unsigned DRP_ON2_LSB     = 19;
  localparam int unsigned DRP_OFF2_LSB    = 11;
  localparam int unsigned DRP_CLAMP2_LSB  = 3;
  localparam int unsigned DRP_HYST_LSB    = 1;
  localparam int unsigned DRP_ROFF1_LSB   = 23;
  localparam int unsigned DRP_RCLAMP1_LSB = 15;
  localparam int unsigned DRP_RA_LSB      = 7;
  localparam int unsigned DRP_RB_HI_LSB   = 0;   // Word 4, 7 bits
  localparam int unsigned DRP_RB_LO_BIT   = 30;  // Word 5, 1 bit

  // ----------------------------------------------------------------
  // Coded field meanings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DRP_MODE_DUTY      = 2'h0,
    DRP_MODE_LINEAR    = 2'h1,
    DRP_MODE_STAIRCASE = 2'h2,
    DRP_MODE_FWD_REV   = 2'h3
  } drp_mode_t;

  // Step duty in hundredths of a percent
  localparam logic [13:0] DRP_STEP_DUTY [8] = '{
    14'd0, 14'd5000, 14'd7500, 14'd8375, 14'd8750, 14'd9375, 14'd9750, 14'd9900
  };
  localparam logic [3:0] DRP_ADV_DEG  [4] = '{4'd0, 4'd5, 4'd10, 4'd15};
  localparam logic [2:0] DRP_HYST_PCT [4] = '{3'd0, 3'd2, 3'd4, 3'd6};

endpackage

// ==== drp_regs_chk.sv ====
/*
  Checker of the profile register bank: APB timing and field updates.
  Assumes it is bound to drp_regs and sees only that module's ports.
*/
`timescale 1ns/1ps
module drp_regs_chk
  import drp_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire logic [2:0]        tri_phase_duty_step_first,
  input wire logic [1:0]        commutation_advance_angle,
  input wire logic [3:0]        advance_degrees,
  input wire drp_mode_t         profile_mode,
  input wire logic [7:0]        duty_point_b,
  input wire logic [7:0]        duty_point_e,
  input wire logic [1:0]        step_change_hysteresis
);
  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Only full-word writes are tracked, so lane masking never trips a check
  wire setup  = psel & ~penable;
  wire mapped = paddr inside {DRP_ADDR_TRI, DRP_ADDR_REF1, DRP_ADDR_REF2,
                              DRP_ADDR_REF3, DRP_ADDR_REF4, DRP_ADDR_REF5};
  wire commit = psel & penable & pwrite & pready & ~pslverr & (pstrb == 4'hf);

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_ready_next: assert property (setup |=> pready)
    else $error("no answer one cycle after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held beyond one cycle");
  a_unmapped_err: assert property (setup && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (setup && mapped |=> !pslverr)
    else $error("mapped access refused");
  a_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("bus outputs active while idle");
  a_mode_write: assert property (commit && paddr == DRP_ADDR_REF1 |=>
    ##1 profile_mode == $past(pwdata[30:29], 2))
    else $error("profile mode not updated");
  a_step_write: assert property (commit && paddr == DRP_ADDR_TRI |=>
    ##1 tri_phase_duty_step_first == $past(pwdata[30:28], 2))
    else $error("step 0 code not updated");
  a_adv_decode: assert property (advance_degrees ==
    {commutation_advance_angle, 2'b00} + 4'(commutation_advance_angle))
    else $error("advance degrees wrong");
  a_point_b: assert property (commit && paddr == DRP_ADDR_REF2 |=>
    ##1 duty_point_b == $past(pwdata[27:20], 2))
    else $error("point B not updated");
  a_hyst_write: assert property (commit && paddr == DRP_ADDR_REF3 |=>
    ##1 step_change_hysteresis == $past(pwdata[2:1], 2))
    else $error("hysteresis not updated");
  a_point_e_lo: assert property (commit && paddr == DRP_ADDR_REF3 |=>
    ##1 duty_point_e[3:0] == $past(pwdata[30:27], 2))
    else $error("point E low part not updated");

  c_write: cover property (commit);
  c_read: cover property (setup && !pwrite && mapped);
  c_refused: cover property (setup && !mapped);
endmodule

bind drp_regs drp_regs_chk #(.ADDR_W(ADDR_W)) u_chk (.clk, .rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .tri_phase_duty_step_first,
  .commutation_advance_angle, .advance_degrees, .profile_mode, .duty_point_b,
  .duty_point_e, .step_change_hysteresis);

// ==== tb_duty_reference_profile_regs.sv ====
/*
  Testbench of the profile register bank: field codes, then table of words,
  lane strobes and a reset in mid-run.
  Assumes drp_regs with a 12-bit byte address and a one-cycle APB answer.
*/
`timescale 1ns/1ps
module tb_duty_reference_profile_regs;
  import drp_pkg::*;
  typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] r; logic e;} drp_row_t;
  logic              clk, rst, psel, penable, pwrite;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [3:0]        pstrb, deg;
  logic              pready, pslverr, er;
  logic [23:0]       codes;
  logic [111:0]      duty;
  logic [2:0]        s0, s4, hpct;
  logic [1:0]        adv, hyst;
  drp_mode_t         mode;
  wire  [14:0][7:0]  f8;
  int                n_fail = 0;
  int                num_checks = 0;
  // Step duty ladder in hundredths of a percent
  logic [13:0] ladder [8] = '{14'h0, 14'h1388, 14'h1d4c, 14'h20b7, 14'h222e, 14'h249f,
                              14'h2616, 14'h26ac};
  logic [7:0]  exp8 [15] = '{8'ha5, 8'h3c, 8'hff, 8'hb5, 8'h81, 8'h42, 8'h99, 8'hc3,
                             8'h11, 8'hee, 8'h5a, 8'h69, 8'h96, 8'h7e, 8'hab};
  // Misaligned and gap addresses sit last so any stray write shows on read
  drp_row_t rows [8] = '{'{DRP_ADDR_TRI, 32'h829c_bbf5, 32'h829c_bbf5, 1'b0},
    '{DRP_ADDR_REF1, 32'h54a7_9ff6, 32'h54a7_9ff6, 1'b0},
    '{DRP_ADDR_REF2, 32'h5814_299c, 32'h5814_299c, 1'b0},
    '{DRP_ADDR_REF3, 32'h188f_72d5, 32'h188f_72d5, 1'b0},
    '{DRP_ADDR_REF4, 32'h34cb_3f55, 32'h34cb_3f55, 1'b0},
    '{DRP_ADDR_REF5, 32'h4000_0abc, 32'h4000_0abc, 1'b0},
    '{12'h264, 32'hdead_beef, 32'h0, 1'b1}, '{12'h26a, 32'h1234_5678, 32'h0, 1'b1}};

  drp_regs u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
    .prdata, .pslverr, .tri_phase_step_codes(codes), .tri_phase_step_duty(duty),
    .tri_phase_duty_step_first(s0), .tri_phase_duty_step_fifth(s4),
    .commutation_advance_angle(adv), .advance_degrees(deg), .profile_mode(mode),
    .turn_on_duty_first(f8[0]), .turn_off_duty_first(f8[1]), .clamp_duty_first(f8[2]),
    .duty_point_a(f8[3]), .duty_point_b(f8[4]), .duty_point_c(f8[5]),
    .duty_point_d(f8[6]), .duty_point_e(f8[7]), .turn_on_duty_second(f8[8]),
    .turn_off_duty_second(f8[9]), .clamp_duty_second(f8[10]),
    .step_change_hysteresis(hyst), .hysteresis_percent(hpct),
    .turn_off_reference_first(f8[11]), .clamp_reference_first(f8[12]),
    .reference_point_a(f8[13]), .reference_point_b(f8[14]));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; values read right after an edge are the pre-edge ones
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic print_verdict;
    $display("Checks %0d, errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // About 31 transfers of 3 cycles are expected; this leaves wide margin
  initial begin
    #20us;
    n_fail++;
    print_verdict();
  end

  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, pstrb} = {1'b1, 47'h0, 4'hf};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, DRP_ADDR_TRI, 32'(i) << 5);
      apb(1'b1, DRP_ADDR_REF1, 32'(i) << 29);
      apb(1'b1, DRP_ADDR_REF3, 32'(i) << 1);
      repeat (2) @(posedge clk);
      chk(32'(adv), i);
      chk(32'(deg), 5 * i);
      chk(32'(hyst), i);
      chk(32'(mode), i);
      chk(32'(hpct), 2 * i);
    end
    foreach (rows[k]) begin
      apb(1'b1, rows[k].a, rows[k].w);
      chk(32'(er), 32'(rows[k].e));
    end
    foreach (rows[k]) begin
      apb(1'b0, rows[k].a, 32'h0);
      chk(rd, rows[k].r);
      chk(32'(er), 32'(rows[k].e));
    end
    for (int i = 0; i < 8; i++) begin
      chk(32'(codes[3*i+:3]), i);
      chk(32'(duty[14*i+:14]), 32'(ladder[i]));
    end
    chk(32'(s0), 0);
    chk(32'(s4), 4);
    foreach (exp8[k]) chk(32'(f8[k]), 32'(exp8[k]));
    // Low lane only: upper bytes must keep their old contents
    pstrb <= 4'h1;
    apb(1'b1, DRP_ADDR_REF4, 32'hffff_ffff);
    pstrb <= 4'hf;
    apb(1'b0, DRP_ADDR_REF4, 32'h0);
    chk(rd, 32'h34cb_3fff);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk(32'(f8[4]), 0);
    chk(32'(mode), 0);
    apb(1'b0, DRP_ADDR_REF2, 32'h0);
    chk(rd, 32'h0);
    print_verdict();
  end
endmodule
